// >>> pkg/pmbus_bank_pkg.sv
/*
 pmbus_bank_pkg: command codes, reset values, field positions, timing constants and carrier types
 for the limit, timing and status command bank.
 assumes: an smbus protocol engine outside turns bus frames into single command requests.
*/
package pmbus_bank_pkg;
   // ***************
   // sizes and timing
   // ***************
   localparam int num_channels = 8;
   localparam int clk_rate_hz = 50_000_000;
   localparam int tick_period_ms = 1;
   localparam int tick_cycles = clk_rate_hz / 1000 * tick_period_ms;
   localparam int l11_frac_bits = 16;
   // ***************
   // command codes
   // ***************
   localparam logic [7:0] cmd_page = 8'h00;
   localparam logic [7:0] cmd_output_mode = 8'h20;
   localparam logic [7:0] cmd_overtemp_warning_limit = 8'h51;
   localparam logic [7:0] cmd_undertemp_warning_limit = 8'h52;
   localparam logic [7:0] cmd_undertemp_fault_limit = 8'h53;
   localparam logic [7:0] cmd_undertemp_fault_action = 8'h54;
   localparam logic [7:0] cmd_input_overvolt_fault_limit = 8'h55;
   localparam logic [7:0] cmd_input_overvolt_fault_action = 8'h56;
   localparam logic [7:0] cmd_input_overvolt_warning_limit = 8'h57;
   localparam logic [7:0] cmd_input_undervolt_warning_limit = 8'h58;
   localparam logic [7:0] cmd_input_undervolt_fault_limit = 8'h59;
   localparam logic [7:0] cmd_input_undervolt_fault_action = 8'h5a;
   localparam logic [7:0] cmd_good_assert_threshold = 8'h5e;
   localparam logic [7:0] cmd_good_deassert_threshold = 8'h5f;
   localparam logic [7:0] cmd_turn_on_delay = 8'h60;
   localparam logic [7:0] cmd_turn_on_rise_time = 8'h61;
   localparam logic [7:0] cmd_turn_on_timeout_limit = 8'h62;
   localparam logic [7:0] cmd_turn_on_timeout_action = 8'h63;
   localparam logic [7:0] cmd_turn_off_delay = 8'h64;
   localparam logic [7:0] cmd_fault_summary_byte = 8'h78;
   localparam logic [7:0] cmd_fault_summary_word = 8'h79;
   localparam logic [7:0] cmd_output_voltage_flags = 8'h7a;
   localparam logic [7:0] cmd_input_voltage_flags = 8'h7c;
   localparam logic [7:0] cmd_temperature_flags = 8'h7d;
   localparam logic [7:0] page_all = 8'hff;
   // ***************
   // reset values
   // ***************
   localparam logic [7:0] rst_page = 8'h00;
   localparam logic [7:0] output_mode_value = 8'h13;
   localparam logic [15:0] rst_overtemp_warning_limit = 16'hea30;
   localparam logic [15:0] rst_undertemp_warning_limit = 16'h8000;
   localparam logic [15:0] rst_undertemp_fault_limit = 16'he580;
   localparam logic [7:0] rst_undertemp_fault_action = 8'hb8;
   localparam logic [15:0] rst_input_overvolt_fault_limit = 16'hd3c0;
   localparam logic [7:0] rst_input_overvolt_fault_action = 8'h80;
   localparam logic [15:0] rst_input_overvolt_warning_limit = 16'hd380;
   localparam logic [15:0] rst_input_undervolt_warning_limit = 16'h8000;
   localparam logic [15:0] rst_input_undervolt_fault_limit = 16'h8000;
   localparam logic [7:0] rst_input_undervolt_fault_action = 8'h00;
   localparam logic [15:0] rst_good_assert_threshold = 16'h1eb8;
   localparam logic [15:0] rst_good_deassert_threshold = 16'h1e14;
   localparam logic [15:0] rst_turn_on_delay = 16'hba00;
   localparam logic [15:0] rst_turn_on_rise_time = 16'hd280;
   localparam logic [15:0] rst_turn_on_timeout_limit = 16'hd3c0;
   localparam logic [7:0] rst_turn_on_timeout_action = 8'hb8;
   localparam logic [15:0] rst_turn_off_delay = 16'hba00;
   // ***************
   // field positions
   // ***************
   localparam int action_hi = 7;
   localparam int action_lo = 6;
   localparam logic [1:0] action_ignore = 2'h0;
   localparam int sb_off = 6;
   localparam int sb_vin_uv = 3;
   localparam int sb_temp = 2;
   localparam int sw_vout = 15;
   localparam int sw_input = 13;
   localparam int sw_good_n = 11;
   localparam int vf_ton_timeout = 2;
   localparam int if_ov_fault = 7;
   localparam int if_ov_warn = 6;
   localparam int if_uv_warn = 5;
   localparam int if_uv_fault = 4;
   localparam int tf_ot_warn = 6;
   localparam int tf_ut_warn = 5;
   localparam int tf_ut_fault = 4;
   // ***************
   // types
   // ***************
   typedef enum logic [2:0] {
      st_off = 3'h0,
      st_delay_on = 3'h1,
      st_rising = 3'h3,
      st_on = 3'h2,
      st_delay_off = 3'h6
   } chan_state_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_req_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } cmd_rsp_t;
endpackage : pmbus_bank_pkg

// >>> core/pmbus_limit_timing_status_bank.sv
/*
 pmbus_limit_timing_status_bank: limit, sequencing timer and status commands with per-channel sequencers.
 assumes: requests come from a protocol engine on ref_clk; measurement words come from the adc on ref_clk;
 run control pins are asynchronous and are synchronised here.
*/
// What this block does
// - power good rises when output word is at or above assert threshold.
// - power good falls when output word is at or below deassert threshold.
// - on request, wait turn-on delay milliseconds, then drive channel enable on.
// - on off request, wait turn-off delay milliseconds, then drive enable off.
// - after enable rises, wait rise time, then start servoing the output.
// - undervoltage lasting past timeout limit after enable raises timeout fault.
// - timeout fault runs the action in the paged timeout action byte.
// - undertemperature fault against its limit runs the undertemperature action byte.
// - input sense voltage is compared against input overvoltage fault limit.
// - input overvoltage fault runs the input overvoltage action byte.
// - input above overvoltage warning limit raises a warning.
// - input below undervoltage warning limit raises a warning.
// - input below undervoltage fault limit raises a fault.
// - input undervoltage fault runs its action byte, default takes no action.
// - read-only paged fault summary byte.
// - read-only paged fault summary word.
// - read-only paged output voltage flags byte.
// - read-only input voltage flags byte.
// - read-only temperature flags byte.
// - page register selects which channel copy paged commands reach.
// - output words are unsigned with fixed exponent minus thirteen.
`timescale 1ns/1ps
module pmbus_limit_timing_status_bank
   import pmbus_bank_pkg::*;
#(
   parameter int unsigned ms_cycles = tick_cycles
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire cmd_req_t cmd_req,
   output cmd_rsp_t cmd_rsp,
   input wire logic [num_channels-1:0] run_control_pin,
   input wire logic [num_channels-1:0] operation_on,
   input wire logic [num_channels-1:0][15:0] output_voltage_word,
   input wire logic [15:0] input_sense_pin_word,
   input wire logic [15:0] temperature_word,
   output logic [num_channels-1:0] channel_output_enable_pin,
   output logic [num_channels-1:0] power_good,
   output logic [num_channels-1:0] servo_start,
   output logic [num_channels-1:0] turn_on_timeout_fault
);
   // ***************
   // state
   // ***************
   typedef struct packed {
      logic [7:0] page;
      logic [15:0] ot_warn_lim;
      logic [15:0] ut_warn_lim;
      logic [15:0] ut_fault_lim;
      logic [7:0] ut_action;
      logic [15:0] vin_ov_fault_lim;
      logic [7:0] vin_ov_action;
      logic [15:0] vin_ov_warn_lim;
      logic [15:0] vin_uv_warn_lim;
      logic [15:0] vin_uv_fault_lim;
      logic [7:0] vin_uv_action;
      logic [num_channels-1:0][15:0] good_on;
      logic [num_channels-1:0][15:0] good_off;
      logic [num_channels-1:0][15:0] on_delay;
      logic [num_channels-1:0][15:0] rise_time;
      logic [num_channels-1:0][15:0] timeout_lim;
      logic [num_channels-1:0][7:0] timeout_action;
      logic [num_channels-1:0][15:0] off_delay;
      chan_state_t [num_channels-1:0] chan;
      logic [num_channels-1:0][15:0] ms_count;
      logic [31:0] prescale;
      logic ms_tick;
      logic [num_channels-1:0] run_meta;
      logic [num_channels-1:0] run_sync;
      logic [num_channels-1:0] enable;
      logic [num_channels-1:0] good;
      logic [num_channels-1:0] reached;
      logic [num_channels-1:0] servo;
      logic [num_channels-1:0] ton_fault;
      logic vin_ov_fault;
      logic vin_ov_warn;
      logic vin_uv_warn;
      logic vin_uv_fault;
      logic ut_fault;
      logic ut_warn;
      logic ot_warn;
      cmd_rsp_t rsp;
   } bank_state_t;

   bank_state_t s;
   bank_state_t next_s;

   // ***************
   // functions
   // ***************
   // signed value scaled by 2^16; the smallest exponent (-16) lands on bit 0, so no bits are lost
   function automatic logic signed [47:0] l11_scaled(input logic [15:0] w);
      logic signed [47:0] mant;
      logic signed [5:0] shift;
      mant = 48'($signed(w[10:0]));
      shift = 6'($signed(w[15:11])) + 6'(l11_frac_bits);
      return mant <<< shift;
   endfunction : l11_scaled

   // whole milliseconds, negative clamps to zero and huge values saturate
   function automatic logic [15:0] l11_ms(input logic [15:0] w);
      logic signed [47:0] v;
      logic signed [47:0] whole;
      v = l11_scaled(w);
      whole = v >>> l11_frac_bits;
      if (whole < 0) begin
         return 16'h0000;
      end
      if (whole > 48'sh00000000ffff) begin
         return 16'hffff;
      end
      return whole[15:0];
   endfunction : l11_ms

   function automatic logic shuts_down(input logic [7:0] action);
      return action[action_hi:action_lo] != action_ignore;
   endfunction : shuts_down

   function automatic bank_state_t reset_value();
      bank_state_t r;
      r = '0;
      r.page = rst_page;
      r.ot_warn_lim = rst_overtemp_warning_limit;
      r.ut_warn_lim = rst_undertemp_warning_limit;
      r.ut_fault_lim = rst_undertemp_fault_limit;
      r.ut_action = rst_undertemp_fault_action;
      r.vin_ov_fault_lim = rst_input_overvolt_fault_limit;
      r.vin_ov_action = rst_input_overvolt_fault_action;
      r.vin_ov_warn_lim = rst_input_overvolt_warning_limit;
      r.vin_uv_warn_lim = rst_input_undervolt_warning_limit;
      r.vin_uv_fault_lim = rst_input_undervolt_fault_limit;
      r.vin_uv_action = rst_input_undervolt_fault_action;
      for (int i = 0; i < num_channels; i++) begin
         r.good_on[i] = rst_good_assert_threshold;
         r.good_off[i] = rst_good_deassert_threshold;
         r.on_delay[i] = rst_turn_on_delay;
         r.rise_time[i] = rst_turn_on_rise_time;
         r.timeout_lim[i] = rst_turn_on_timeout_limit;
         r.timeout_action[i] = rst_turn_on_timeout_action;
         r.off_delay[i] = rst_turn_off_delay;
         r.chan[i] = st_off;
      end
      return r;
   endfunction : reset_value

   // ***************
   // next state
   // ***************
   always_comb begin
      logic [2:0] p;
      logic kill;
      logic req;
      logic [7:0] sbyte;
      logic [15:0] rdata;
      logic [15:0] vout;
      p = '0;
      kill = 1'b0;
      req = 1'b0;
      sbyte = '0;
      rdata = '0;
      vout = '0;
      next_s = s;
      p = s.page[2:0];
      next_s.run_meta = run_control_pin;
      next_s.run_sync = s.run_meta;

      // free-running millisecond tick shared by every channel timer
      next_s.ms_tick = 1'b0;
      if (s.prescale >= 32'(ms_cycles - 1)) begin
         next_s.prescale = '0;
         next_s.ms_tick = 1'b1;
      end else begin
         next_s.prescale = s.prescale + 32'h1;
      end

      // input and temperature supervision, live flags
      next_s.vin_ov_fault = l11_scaled(input_sense_pin_word) > l11_scaled(s.vin_ov_fault_lim);
      next_s.vin_ov_warn = l11_scaled(input_sense_pin_word) > l11_scaled(s.vin_ov_warn_lim);
      next_s.vin_uv_warn = l11_scaled(input_sense_pin_word) < l11_scaled(s.vin_uv_warn_lim);
      next_s.vin_uv_fault = l11_scaled(input_sense_pin_word) < l11_scaled(s.vin_uv_fault_lim);
      next_s.ut_fault = l11_scaled(temperature_word) < l11_scaled(s.ut_fault_lim);
      next_s.ut_warn = l11_scaled(temperature_word) < l11_scaled(s.ut_warn_lim);
      next_s.ot_warn = l11_scaled(temperature_word) > l11_scaled(s.ot_warn_lim);
      kill = (s.ut_fault && shuts_down(s.ut_action))
         || (s.vin_ov_fault && shuts_down(s.vin_ov_action))
         || (s.vin_uv_fault && shuts_down(s.vin_uv_action));

      // per channel sequencer
      for (int i = 0; i < num_channels; i++) begin
         vout = output_voltage_word[i];
         // same fixed exponent on both sides, so the raw unsigned words compare directly
         if (vout >= s.good_on[i]) begin
            next_s.good[i] = 1'b1;
         end else if (vout <= s.good_off[i]) begin
            next_s.good[i] = 1'b0;
         end
         if (s.ms_tick && s.ms_count[i] != 16'hffff) begin
            next_s.ms_count[i] = s.ms_count[i] + 16'h1;
         end
         req = s.run_sync[i] && operation_on[i] && !kill && !s.ton_fault[i];
         // the fault holds until the request is withdrawn
         if (!(s.run_sync[i] && operation_on[i])) begin
            next_s.ton_fault[i] = 1'b0;
         end
         unique case (s.chan[i])
            st_off: begin
               if (req) begin
                  next_s.chan[i] = st_delay_on;
                  next_s.ms_count[i] = '0;
               end
            end
            st_delay_on: begin
               if (!req) begin
                  next_s.chan[i] = st_off;
               end else if (s.ms_count[i] >= l11_ms(s.on_delay[i])) begin
                  next_s.chan[i] = st_rising;
                  next_s.enable[i] = 1'b1;
                  next_s.reached[i] = 1'b0;
                  next_s.ms_count[i] = '0;
               end
            end
            st_rising, st_on: begin
               if (s.chan[i] == st_rising && s.ms_count[i] >= l11_ms(s.rise_time[i])) begin
                  next_s.chan[i] = st_on;
                  next_s.servo[i] = 1'b1;
               end
               if (s.good[i]) begin
                  next_s.reached[i] = 1'b1;
               end
               if (!s.reached[i] && !s.good[i] && s.ms_count[i] >= l11_ms(s.timeout_lim[i])) begin
                  next_s.ton_fault[i] = 1'b1;
                  if (shuts_down(s.timeout_action[i])) begin
                     next_s.chan[i] = st_off;
                     next_s.enable[i] = 1'b0;
                     next_s.servo[i] = 1'b0;
                  end
               end else if (kill) begin
                  // a shutdown fault drops the output at once, skipping the off delay
                  next_s.chan[i] = st_off;
                  next_s.enable[i] = 1'b0;
                  next_s.servo[i] = 1'b0;
               end else if (!req) begin
                  next_s.chan[i] = st_delay_off;
                  next_s.ms_count[i] = '0;
               end
            end
            st_delay_off: begin
               if (kill || s.ms_count[i] >= l11_ms(s.off_delay[i])) begin
                  next_s.chan[i] = st_off;
                  next_s.enable[i] = 1'b0;
                  next_s.servo[i] = 1'b0;
               end else if (req) begin
                  next_s.chan[i] = st_on;
               end
            end
            default: begin
               next_s.chan[i] = st_off;
               next_s.enable[i] = 1'b0;
               next_s.servo[i] = 1'b0;
            end
         endcase
      end

      // command writes; page 0xff reaches every channel copy
      if (cmd_req.valid && cmd_req.write) begin
         unique case (cmd_req.code)
            cmd_page: next_s.page = cmd_req.data[7:0];
            cmd_overtemp_warning_limit: next_s.ot_warn_lim = cmd_req.data;
            cmd_undertemp_warning_limit: next_s.ut_warn_lim = cmd_req.data;
            cmd_undertemp_fault_limit: next_s.ut_fault_lim = cmd_req.data;
            cmd_undertemp_fault_action: next_s.ut_action = cmd_req.data[7:0];
            cmd_input_overvolt_fault_limit: next_s.vin_ov_fault_lim = cmd_req.data;
            cmd_input_overvolt_fault_action: next_s.vin_ov_action = cmd_req.data[7:0];
            cmd_input_overvolt_warning_limit: next_s.vin_ov_warn_lim = cmd_req.data;
            cmd_input_undervolt_warning_limit: next_s.vin_uv_warn_lim = cmd_req.data;
            cmd_input_undervolt_fault_limit: next_s.vin_uv_fault_lim = cmd_req.data;
            cmd_input_undervolt_fault_action: next_s.vin_uv_action = cmd_req.data[7:0];
            default: begin
               // status codes and unknown codes fall through untouched
               for (int i = 0; i < num_channels; i++) begin
                  if (s.page == page_all || p == 3'(i)) begin
                     unique case (cmd_req.code)
                        cmd_good_assert_threshold: next_s.good_on[i] = cmd_req.data;
                        cmd_good_deassert_threshold: next_s.good_off[i] = cmd_req.data;
                        cmd_turn_on_delay: next_s.on_delay[i] = cmd_req.data;
                        cmd_turn_on_rise_time: next_s.rise_time[i] = cmd_req.data;
                        cmd_turn_on_timeout_limit: next_s.timeout_lim[i] = cmd_req.data;
                        cmd_turn_on_timeout_action: next_s.timeout_action[i] = cmd_req.data[7:0];
                        cmd_turn_off_delay: next_s.off_delay[i] = cmd_req.data;
                        default: ;
                     endcase
                  end
               end
            end
         endcase
      end

      // command reads, answered one cycle later; narrow commands sit in the low byte
      sbyte = '0;
      sbyte[sb_off] = !s.enable[p];
      sbyte[sb_vin_uv] = s.vin_uv_fault;
      sbyte[sb_temp] = s.ut_fault;
      unique case (cmd_req.code)
         cmd_page: rdata = {8'h00, s.page};
         cmd_output_mode: rdata = {8'h00, output_mode_value};
         cmd_overtemp_warning_limit: rdata = s.ot_warn_lim;
         cmd_undertemp_warning_limit: rdata = s.ut_warn_lim;
         cmd_undertemp_fault_limit: rdata = s.ut_fault_lim;
         cmd_undertemp_fault_action: rdata = {8'h00, s.ut_action};
         cmd_input_overvolt_fault_limit: rdata = s.vin_ov_fault_lim;
         cmd_input_overvolt_fault_action: rdata = {8'h00, s.vin_ov_action};
         cmd_input_overvolt_warning_limit: rdata = s.vin_ov_warn_lim;
         cmd_input_undervolt_warning_limit: rdata = s.vin_uv_warn_lim;
         cmd_input_undervolt_fault_limit: rdata = s.vin_uv_fault_lim;
         cmd_input_undervolt_fault_action: rdata = {8'h00, s.vin_uv_action};
         cmd_good_assert_threshold: rdata = s.good_on[p];
         cmd_good_deassert_threshold: rdata = s.good_off[p];
         cmd_turn_on_delay: rdata = s.on_delay[p];
         cmd_turn_on_rise_time: rdata = s.rise_time[p];
         cmd_turn_on_timeout_limit: rdata = s.timeout_lim[p];
         cmd_turn_on_timeout_action: rdata = {8'h00, s.timeout_action[p]};
         cmd_turn_off_delay: rdata = s.off_delay[p];
         cmd_fault_summary_byte: rdata = {8'h00, sbyte};
         cmd_fault_summary_word: begin
            rdata = {8'h00, sbyte};
            rdata[sw_vout] = s.ton_fault[p];
            rdata[sw_input] = s.vin_ov_fault || s.vin_ov_warn || s.vin_uv_warn || s.vin_uv_fault;
            rdata[sw_good_n] = !s.good[p];
         end
         cmd_output_voltage_flags: rdata[vf_ton_timeout] = s.ton_fault[p];
         cmd_input_voltage_flags: begin
            rdata[if_ov_fault] = s.vin_ov_fault;
            rdata[if_ov_warn] = s.vin_ov_warn;
            rdata[if_uv_warn] = s.vin_uv_warn;
            rdata[if_uv_fault] = s.vin_uv_fault;
         end
         cmd_temperature_flags: begin
            rdata[tf_ot_warn] = s.ot_warn;
            rdata[tf_ut_warn] = s.ut_warn;
            rdata[tf_ut_fault] = s.ut_fault;
         end
         default: rdata = '0;
      endcase
      next_s.rsp.valid = cmd_req.valid && !cmd_req.write;
      next_s.rsp.data = (cmd_req.valid && !cmd_req.write) ? rdata : '0;

      if (rst) begin
         next_s = reset_value();
      end
   end

   always_ff @(posedge ref_clk) begin
      s <= next_s;
   end

   // ***************
   // outputs
   // ***************
   assign cmd_rsp = s.rsp;
   assign channel_output_enable_pin = s.enable;
   assign power_good = s.good;
   assign servo_start = s.servo;
   assign turn_on_timeout_fault = s.ton_fault;
endmodule : pmbus_limit_timing_status_bank

// >>> testbench/pmbus_bank_sva.sv
/* pmbus_bank_sva: port assertions for the command bank.
   assumes: one clock, synchronous reset; bound to the bank below. */
`timescale 1ns/1ps
module pmbus_bank_sva
   import pmbus_bank_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire cmd_req_t cmd_req,
   input wire cmd_rsp_t cmd_rsp,
   input wire logic [num_channels-1:0] operation_on,
   input wire logic [num_channels-1:0] channel_output_enable_pin,
   input wire logic [num_channels-1:0] servo_start,
   input wire logic [num_channels-1:0] turn_on_timeout_fault
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence rd_taken; cmd_req.valid && !cmd_req.write; endsequence
   sequence answered; cmd_rsp.valid; endsequence
   AST_READ_ANSWER: assert property (rd_taken |=> answered)
      else $error("read not answered next cycle");
   AST_ANSWER_CAUSE: assert property (answered |-> $past(cmd_req.valid) && !$past(cmd_req.write))
      else $error("answer without a read");
   AST_IDLE_ZERO: assert property (!cmd_rsp.valid |-> cmd_rsp.data == 16'h0000)
      else $error("idle answer data not zero");
   AST_MODE_FIXED: assert property (rd_taken ##0 cmd_req.code == cmd_output_mode
      |=> cmd_rsp.data == 16'h0013) else $error("output mode read wrong");
   AST_BYTE_HIGH_ZERO: assert property (rd_taken ##0 cmd_req.code == cmd_fault_summary_byte
      |=> cmd_rsp.data[15:8] == 8'h00) else $error("summary byte upper half not zero");
   AST_ENABLE_CAUSE: assert property ((channel_output_enable_pin & ~$past(channel_output_enable_pin)
      & ~$past(operation_on)) == 8'h00) else $error("enable rose without on request");
   AST_SERVO_AFTER_EN: assert property ((servo_start & ~$past(servo_start)
      & ~$past(channel_output_enable_pin)) == 8'h00) else $error("servo started before enable");
   AST_TIMEOUT_AFTER_EN: assert property ((turn_on_timeout_fault & ~$past(turn_on_timeout_fault)
      & ~$past(channel_output_enable_pin)) == 8'h00) else $error("timeout fault without enable");
endmodule : pmbus_bank_sva
bind pmbus_limit_timing_status_bank pmbus_bank_sva u_pmbus_bank_sva (.ref_clk(ref_clk), .rst(rst),
   .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .operation_on(operation_on), .servo_start(servo_start),
   .channel_output_enable_pin(channel_output_enable_pin), .turn_on_timeout_fault(turn_on_timeout_fault));

// >>> testbench/pmbus_host_model.sv
/* pmbus_host_model: host issuing one command request at a time.
   assumes: reads are answered one cycle after the taking edge. */
`timescale 1ns/1ps
module pmbus_host_model
   import pmbus_bank_pkg::*;
(
   input wire logic ref_clk,
   output cmd_req_t cmd_req,
   input wire cmd_rsp_t cmd_rsp
);
   initial cmd_req = '0;
   task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
      @(posedge ref_clk);
      cmd_req <= '{1'b1, wr, c, d};
      @(posedge ref_clk);
      // idle lines carry the inverse so a stale code or word never looks fresh
      cmd_req <= '{1'b0, 1'b0, ~c, ~d};
      @(posedge ref_clk);
      q = (cmd_rsp.valid === 1'b1) ? cmd_rsp.data : 16'hxxxx;
   endtask : xfer
endmodule : pmbus_host_model

// >>> testbench/testbench.sv
/* testbench: drives the bank through the host model, supervision words and run pins from here.
   assumes: ms_cycles shortened to msc clocks so sequencing ends quickly. */
`timescale 1ns/1ps
module testbench;
   import pmbus_bank_pkg::*;
   localparam int msc = 10;
   logic ref_clk = 1'b0, rst = 1'b1;
   cmd_req_t cmd_req;
   cmd_rsp_t cmd_rsp;
   logic [7:0] run = 8'h00, op_on = 8'h00, en, pg, servo, tmo;
   logic [7:0][15:0] vout = '0;
   // 13 V in and 25 C keep every input and temperature flag quiet
   logic [15:0] vin = 16'hd340, temp = 16'he8c8, q;
   logic [15:0] wv[2][17];
   int n_fail = 0, n_tests = 0, cyc = 0, n;
   logic [7:0] cd[17] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h5f,
      8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
   logic [15:0] rv[17] = '{16'hea30, 16'h8000, 16'he580, 16'h00b8, 16'hd3c0, 16'h0080, 16'hd380, 16'h8000,
      16'h8000, 16'h0000, 16'h1eb8, 16'h1e14, 16'hba00, 16'hd280, 16'hd3c0, 16'h00b8, 16'hba00};
   pmbus_host_model u_pmbus_host_model (.ref_clk(ref_clk), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp));
   pmbus_limit_timing_status_bank #(.ms_cycles(msc)) u_pmbus_limit_timing_status_bank (.ref_clk(ref_clk),
      .rst(rst), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .run_control_pin(run), .operation_on(op_on),
      .output_voltage_word(vout), .input_sense_pin_word(vin), .temperature_word(temp),
      .channel_output_enable_pin(en), .power_good(pg), .servo_start(servo), .turn_on_timeout_fault(tmo));
   function automatic logic [15:0] wmask(input logic [7:0] c, input logic [15:0] v);
      return (c == 8'h54 || c == 8'h56 || c == 8'h5a || c == 8'h63) ? {8'h00, v[7:0]} : v;
   endfunction : wmask
   task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      u_pmbus_host_model.xfer(1'b1, c, d, q);
   endtask : wr
   task automatic rd(input string s, input logic [7:0] c, input logic [15:0] e);
      u_pmbus_host_model.xfer(1'b0, c, 16'h0000, q);
      check(s, q, e);
   endtask : rd
   task automatic wait_en(input int ch, input logic lvl);
      n = 0;
      while (en[ch] !== lvl && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
   endtask : wait_en
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(60057));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 17; i++) rd("reset value", cd[i], rv[i]);
      for (int k = 0; k < 2; k++) begin
         wr(8'h00, 16'(3 + 2 * k));
         for (int i = 0; i < 17; i++) begin
            wv[k][i] = 16'($urandom);
            wr(cd[i], wv[k][i]);
         end
      end
      wr(8'h00, 16'h0003);
      for (int i = 0; i < 17; i++) rd("page copy", cd[i], wmask(cd[i], wv[cd[i] < 8'h5e][i]));
      // random limits may have tripped shutdowns, so start the sequencing part clean
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      wr(8'h00, 16'h0002);
      wr(8'h60, 16'h0003);
      wr(8'h61, 16'h0002);
      wr(8'h64, 16'h0003);
      run <= 8'h14;
      op_on <= 8'h14;
      wait_en(2, 1'b1);
      check("on delay", 16'(n >= 2 * msc && n <= 4 * msc + 6), 16'h0001);
      vout[2] <= 16'h1eb8;
      repeat (3) @(posedge ref_clk);
      check("good at on level", pg[2], 1'b1);
      vout[2] <= 16'h1e15;
      repeat (3) @(posedge ref_clk);
      check("good held", pg[2], 1'b1);
      vout[2] <= 16'h1e14;
      repeat (3 * msc) @(posedge ref_clk);
      check("good at off level", pg[2], 1'b0);
      check("servo", servo[2], 1'b1);
      repeat (13 * msc) @(posedge ref_clk);
      check("timeout", {tmo[4], en[4], en[2]}, 16'h0005);
      op_on <= 8'h10;
      wait_en(2, 1'b0);
      check("off delay", 16'(n >= 2 * msc && n <= 4 * msc + 6), 16'h0001);
      wr(8'h00, 16'h0000);
      vin <= 16'hd3e0;
      wr(8'h7c, 16'hffff);
      rd("input flags", 8'h7c, 16'h00c0);
      rd("summary byte", 8'h78, 16'h0040);
      rd("summary word", 8'h79, 16'h2840);
      rd("vout flags", 8'h7a, 16'h0000);
      rd("temp flags", 8'h7d, 16'h0000);
      rd("vout mode", 8'h20, 16'h0013);
      vin <= 16'h87ff;
      rd("input uv flags", 8'h7c, 16'h0030);
      give_verdict();
   end
endmodule : testbench
